/* tdc_pkg.sv */
/*
 * Shared constants of the dual timer/counter block: special function register
 * addresses, control and mode field positions, mode codes, reset values and
 * the machine-cycle timing. Assumes an 8-bit special function register space.
 */
`default_nettype none

package tdc_pkg;

	// Special function register addresses.
	localparam logic [7:0] TIMER_RUN_AND_EXT_INT_CONTROL_ADDR = 8'h88;
	localparam logic [7:0] TIMER_MODE_SELECT_ADDR = 8'h89;
	localparam logic [7:0] TMR0_LOW_BYTE_ADDR = 8'h8A;
	localparam logic [7:0] TMR1_LOW_BYTE_ADDR = 8'h8B;
	localparam logic [7:0] TMR0_HIGH_BYTE_ADDR = 8'h8C;
	localparam logic [7:0] TMR1_HIGH_BYTE_ADDR = 8'h8D;

	// Run and external interrupt control register bit positions.
	localparam int unsigned TMR1_OVERFLOW_FLAG_BIT = 7;
	localparam int unsigned TMR1_RUN_CONTROL_BIT = 6;
	localparam int unsigned TMR0_OVERFLOW_FLAG_BIT = 5;
	localparam int unsigned TMR0_RUN_CONTROL_BIT = 4;
	localparam int unsigned EXT_IRQ1_FLAG_BIT = 3;
	localparam int unsigned EXT_IRQ1_TYPE_BIT = 2;
	localparam int unsigned EXT_IRQ0_FLAG_BIT = 1;
	localparam int unsigned EXT_IRQ0_TYPE_BIT = 0;

	// Mode select register bit positions.
	localparam int unsigned TMR1_PIN_GATING_BIT = 7;
	localparam int unsigned TMR1_SOURCE_SELECT_BIT = 6;
	localparam int unsigned TMR1_MODE_LSB = 4;
	localparam int unsigned TMR0_PIN_GATING_BIT = 3;
	localparam int unsigned TMR0_SOURCE_SELECT_BIT = 2;
	localparam int unsigned TMR0_MODE_LSB = 0;

	// Mode codes of the two-bit mode field.
	localparam logic [1:0] MODE_13BIT = 2'h0;
	localparam logic [1:0] MODE_16BIT = 2'h1;
	localparam logic [1:0] MODE_AUTO_RELOAD = 2'h2;
	localparam logic [1:0] MODE_SPLIT = 2'h3;

	// Reset values.
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;

	// Machine cycle timing: the core clock is the oscillator.
	localparam int unsigned OSC_PERIOD_NS = 50;
	localparam int unsigned MACHINE_CYCLE_NS = 600;
	localparam int unsigned MCYCLE_CLKS = MACHINE_CYCLE_NS / OSC_PERIOD_NS;

endpackage

`default_nettype wire

/* tdc_mcycle_div.sv */
/*
 * Machine cycle divider: emits a one-clock tick once every DIV core clocks.
 * Assumes core_clk is the oscillator and nrst an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module tdc_mcycle_div #(
	parameter int unsigned DIV = tdc_pkg::MCYCLE_CLKS,
	parameter int unsigned W = 4
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic nrst,
	// Machine cycle tick.
	output logic mtick
);

	// Divider state: the phase counter and the registered tick.
	typedef struct packed {
		logic [W-1:0] phase;
		logic tick;
	} tdc_div_state_t;

	tdc_div_state_t st_r;
	tdc_div_state_t st_nxt;

	// The tick is registered so it is glitch free for every timer that uses it.
	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = (st_r.phase == W'(DIV - 1));
		if (st_r.phase == W'(DIV - 1)) begin
			st_nxt.phase = '0;
		end else begin
			st_nxt.phase = W'(st_r.phase + W'(1));
		end
	end

	// State register.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign mtick = st_r.tick;

	a_mcycle_period: assert property (@(posedge core_clk) disable iff (!nrst)
		mtick |-> ##12 mtick) else $error("machine cycle tick period wrong");
	a_mcycle_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
		mtick |=> !mtick [*8]) else $error("machine cycle tick repeated early");

endmodule // tdc_mcycle_div

`default_nettype wire

/* tdc_fall_sampler.sv */
/*
 * Falling-event sampler: samples a pin once per machine cycle and flags a
 * high sample followed by a low one. Assumes the pin is synchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module tdc_fall_sampler (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic nrst,
	// Sample strobe and pin.
	input wire logic mtick,
	input wire logic pin,
	// One-clock pulse on a detected high-to-low event.
	output logic fall
);

	// Sampler state: the previous machine-cycle sample.
	typedef struct packed {
		logic prev;
	} tdc_smp_state_t;

	tdc_smp_state_t st_r;
	tdc_smp_state_t st_nxt;

	// Take a new sample only on the tick, so a level shorter than one machine
	// cycle may be missed; the far side must hold each level long enough.
	always_comb begin
		st_nxt = st_r;
		if (mtick) begin
			st_nxt.prev = pin;
		end
	end

	// State register; reset to low so no event is seen right after reset.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// High sample then low sample gives one event, two machine cycles in all.
	assign fall = mtick & st_r.prev & ~pin;

endmodule // tdc_fall_sampler

`default_nettype wire

/* tdc_timer_pair.sv */
/*
 * Two 16-bit timer/counters with four modes, external interrupt type and flag
 * logic, reached through the special function register port of the core.
 * Assumes all inputs are synchronous to core_clk, which is the oscillator.
 */
`timescale 1ns/1ps
`default_nettype none

module tdc_timer_pair (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic nrst,
	// Special function register port.
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr_en,
	input wire logic [7:0] sfr_wr_data,
	input wire logic sfr_rd_en,
	output logic [7:0] sfr_rd_data,
	// Pins.
	input wire logic ext_irq_pin_zero,
	input wire logic ext_irq_pin_one,
	input wire logic count_pin_zero,
	input wire logic count_pin_one,
	// Interrupt service acknowledges from the core.
	input wire logic tmr0_irq_ack,
	input wire logic tmr1_irq_ack,
	input wire logic ext_irq0_ack,
	input wire logic ext_irq1_ack,
	// Interrupt requests and serial port rate source.
	output logic tmr0_irq,
	output logic tmr1_irq,
	output logic ext_irq0_req,
	output logic ext_irq1_req,
	output logic tmr1_ovf_pulse
);

	// All state of the block: registers, counter bytes and read data.
	typedef struct packed {
		logic [7:0] control;
		logic [7:0] mode;
		logic [7:0] tmr0_low_byte;
		logic [7:0] tmr0_high_byte;
		logic [7:0] tmr1_low_byte;
		logic [7:0] tmr1_high_byte;
		logic ovf_pulse;
		logic [7:0] rd_data;
	} tdc_pair_state_t;

	tdc_pair_state_t st_r;
	tdc_pair_state_t st_nxt;

	// Machine cycle tick and pin events.
	logic mtick;
	logic fall_cnt0;
	logic fall_cnt1;
	logic fall_irq0;
	logic fall_irq1;

	// Decoded fields and counting terms.
	logic [1:0] tmr0_mode;
	logic [1:0] tmr1_mode;
	logic split0;
	logic cnt_en0;
	logic cnt_en1;
	logic hi0_en;
	logic [16:0] step0;
	logic [16:0] step1;
	logic ovf0;
	logic ovf1;
	logic hi0_ovf;
	logic wr_ctrl;
	logic wr_mode;
	logic wr_lo0;
	logic wr_hi0;
	logic wr_lo1;
	logic wr_hi1;

	// One increment of a counter pair in a given mode; returns {ovf, high, low}.
	// In split mode only the low byte moves; the high byte is handled apart.
	function automatic logic [16:0] tdc_step(input logic [1:0] mode,
		input logic [7:0] lo, input logic [7:0] hi);
		logic [12:0] v13;
		logic [15:0] v16;
		logic [16:0] res;
		v13 = 13'h0000;
		v16 = 16'h0000;
		res = {1'b0, hi, lo};
		unique case (mode)
			tdc_pkg::MODE_13BIT: begin
				v13 = {hi, lo[4:0]} + 13'h0001;
				res = {(&{hi, lo[4:0]}), v13[12:5], lo[7:5], v13[4:0]};
			end
			tdc_pkg::MODE_16BIT: begin
				v16 = {hi, lo} + 16'h0001;
				res = {(&{hi, lo}), v16};
			end
			tdc_pkg::MODE_AUTO_RELOAD: begin
				// Overflow reloads the low byte and leaves the high byte alone.
				res = {(&lo), hi, ((&lo) ? hi : 8'(lo + 8'h01))};
			end
			tdc_pkg::MODE_SPLIT: begin
				res = {(&lo), hi, 8'(lo + 8'h01)};
			end
		endcase
		return res;
	endfunction

	// Machine cycle divider shared by all counters and samplers.
	tdc_mcycle_div u_div (
		.core_clk(core_clk),
		.nrst(nrst),
		.mtick(mtick)
	);

	// Event samplers for the two count pins and the two interrupt pins.
	tdc_fall_sampler u_cnt0 (
		.core_clk(core_clk),
		.nrst(nrst),
		.mtick(mtick),
		.pin(count_pin_zero),
		.fall(fall_cnt0)
	);
	tdc_fall_sampler u_cnt1 (
		.core_clk(core_clk),
		.nrst(nrst),
		.mtick(mtick),
		.pin(count_pin_one),
		.fall(fall_cnt1)
	);
	tdc_fall_sampler u_irq0 (
		.core_clk(core_clk),
		.nrst(nrst),
		.mtick(mtick),
		.pin(ext_irq_pin_zero),
		.fall(fall_irq0)
	);
	tdc_fall_sampler u_irq1 (
		.core_clk(core_clk),
		.nrst(nrst),
		.mtick(mtick),
		.pin(ext_irq_pin_one),
		.fall(fall_irq1)
	);

	// Register write decode.
	assign wr_ctrl = sfr_wr_en & (sfr_addr == tdc_pkg::TIMER_RUN_AND_EXT_INT_CONTROL_ADDR);
	assign wr_mode = sfr_wr_en & (sfr_addr == tdc_pkg::TIMER_MODE_SELECT_ADDR);
	assign wr_lo0 = sfr_wr_en & (sfr_addr == tdc_pkg::TMR0_LOW_BYTE_ADDR);
	assign wr_hi0 = sfr_wr_en & (sfr_addr == tdc_pkg::TMR0_HIGH_BYTE_ADDR);
	assign wr_lo1 = sfr_wr_en & (sfr_addr == tdc_pkg::TMR1_LOW_BYTE_ADDR);
	assign wr_hi1 = sfr_wr_en & (sfr_addr == tdc_pkg::TMR1_HIGH_BYTE_ADDR);

	assign tmr0_mode = st_r.mode[tdc_pkg::TMR0_MODE_LSB +: 2];
	assign tmr1_mode = st_r.mode[tdc_pkg::TMR1_MODE_LSB +: 2];
	assign split0 = (tmr0_mode == tdc_pkg::MODE_SPLIT);

	// Count enables: run bit, optional pin gating, then cycle or pin event.
	assign cnt_en0 = st_r.control[tdc_pkg::TMR0_RUN_CONTROL_BIT]
		& (~st_r.mode[tdc_pkg::TMR0_PIN_GATING_BIT] | ext_irq_pin_zero)
		& (st_r.mode[tdc_pkg::TMR0_SOURCE_SELECT_BIT] ? fall_cnt0 : mtick);
	// Timer 1 in split mode behaves as if its run bit were clear.
	assign cnt_en1 = st_r.control[tdc_pkg::TMR1_RUN_CONTROL_BIT]
		& (~st_r.mode[tdc_pkg::TMR1_PIN_GATING_BIT] | ext_irq_pin_one)
		& (st_r.mode[tdc_pkg::TMR1_SOURCE_SELECT_BIT] ? fall_cnt1 : mtick)
		& (tmr1_mode != tdc_pkg::MODE_SPLIT);
	// In split mode the timer 0 high byte counts cycles under timer 1's run bit.
	assign hi0_en = split0 & st_r.control[tdc_pkg::TMR1_RUN_CONTROL_BIT] & mtick;

	assign step0 = tdc_step(tmr0_mode, st_r.tmr0_low_byte, st_r.tmr0_high_byte);
	assign step1 = tdc_step(tmr1_mode, st_r.tmr1_low_byte, st_r.tmr1_high_byte);
	assign ovf0 = cnt_en0 & step0[16];
	assign ovf1 = cnt_en1 & step1[16];
	assign hi0_ovf = hi0_en & (&st_r.tmr0_high_byte);

	// Next-state logic: counting first, then software writes, then flags.
	always_comb begin
		st_nxt = st_r;
		// Timer 0 counting.
		if (cnt_en0) begin
			st_nxt.tmr0_low_byte = step0[7:0];
			if (!split0) begin
				st_nxt.tmr0_high_byte = step0[15:8];
			end
		end
		if (hi0_en) begin
			st_nxt.tmr0_high_byte = 8'(st_r.tmr0_high_byte + 8'h01);
		end
		// Timer 1 counting.
		if (cnt_en1) begin
			st_nxt.tmr1_low_byte = step1[7:0];
			st_nxt.tmr1_high_byte = step1[15:8];
		end
		// A software write to a counter byte wins over a count in that cycle.
		if (wr_lo0) begin
			st_nxt.tmr0_low_byte = sfr_wr_data;
		end
		if (wr_hi0) begin
			st_nxt.tmr0_high_byte = sfr_wr_data;
		end
		if (wr_lo1) begin
			st_nxt.tmr1_low_byte = sfr_wr_data;
		end
		if (wr_hi1) begin
			st_nxt.tmr1_high_byte = sfr_wr_data;
		end
		if (wr_mode) begin
			st_nxt.mode = sfr_wr_data;
		end
		if (wr_ctrl) begin
			st_nxt.control = sfr_wr_data;
		end
		// Service acknowledges clear flags; level-type external flags stay.
		if (tmr0_irq_ack) begin
			st_nxt.control[tdc_pkg::TMR0_OVERFLOW_FLAG_BIT] = 1'b0;
		end
		if (tmr1_irq_ack) begin
			st_nxt.control[tdc_pkg::TMR1_OVERFLOW_FLAG_BIT] = 1'b0;
		end
		if (ext_irq0_ack && st_r.control[tdc_pkg::EXT_IRQ0_TYPE_BIT]) begin
			st_nxt.control[tdc_pkg::EXT_IRQ0_FLAG_BIT] = 1'b0;
		end
		if (ext_irq1_ack && st_r.control[tdc_pkg::EXT_IRQ1_TYPE_BIT]) begin
			st_nxt.control[tdc_pkg::EXT_IRQ1_FLAG_BIT] = 1'b0;
		end
		// Hardware sets come last so an event is never lost to a clear.
		if (ovf0) begin
			st_nxt.control[tdc_pkg::TMR0_OVERFLOW_FLAG_BIT] = 1'b1;
		end
		if (split0 ? hi0_ovf : ovf1) begin
			st_nxt.control[tdc_pkg::TMR1_OVERFLOW_FLAG_BIT] = 1'b1;
		end
		if (st_r.control[tdc_pkg::EXT_IRQ0_TYPE_BIT] ? fall_irq0 : ~ext_irq_pin_zero) begin
			st_nxt.control[tdc_pkg::EXT_IRQ0_FLAG_BIT] = 1'b1;
		end
		if (st_r.control[tdc_pkg::EXT_IRQ1_TYPE_BIT] ? fall_irq1 : ~ext_irq_pin_one) begin
			st_nxt.control[tdc_pkg::EXT_IRQ1_FLAG_BIT] = 1'b1;
		end
		// Serial port rate source sees every real timer 1 overflow.
		st_nxt.ovf_pulse = ovf1;
		// Registered read port; unmapped addresses read as zero.
		if (sfr_rd_en) begin
			unique case (sfr_addr)
				tdc_pkg::TIMER_RUN_AND_EXT_INT_CONTROL_ADDR: st_nxt.rd_data = st_r.control;
				tdc_pkg::TIMER_MODE_SELECT_ADDR: st_nxt.rd_data = st_r.mode;
				tdc_pkg::TMR0_LOW_BYTE_ADDR: st_nxt.rd_data = st_r.tmr0_low_byte;
				tdc_pkg::TMR0_HIGH_BYTE_ADDR: st_nxt.rd_data = st_r.tmr0_high_byte;
				tdc_pkg::TMR1_LOW_BYTE_ADDR: st_nxt.rd_data = st_r.tmr1_low_byte;
				tdc_pkg::TMR1_HIGH_BYTE_ADDR: st_nxt.rd_data = st_r.tmr1_high_byte;
				default: st_nxt.rd_data = 8'h00;
			endcase
		end
	end

	// State register; reset leaves both timers stopped in 13-bit timer mode.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_r.control <= tdc_pkg::CONTROL_RESET;
			st_r.mode <= tdc_pkg::MODE_RESET;
			st_r.tmr0_low_byte <= tdc_pkg::COUNT_RESET;
			st_r.tmr0_high_byte <= tdc_pkg::COUNT_RESET;
			st_r.tmr1_low_byte <= tdc_pkg::COUNT_RESET;
			st_r.tmr1_high_byte <= tdc_pkg::COUNT_RESET;
			st_r.ovf_pulse <= 1'b0;
			st_r.rd_data <= 8'h00;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the register state.
	assign sfr_rd_data = st_r.rd_data;
	assign tmr0_irq = st_r.control[tdc_pkg::TMR0_OVERFLOW_FLAG_BIT];
	assign tmr1_irq = st_r.control[tdc_pkg::TMR1_OVERFLOW_FLAG_BIT];
	assign ext_irq0_req = st_r.control[tdc_pkg::EXT_IRQ0_FLAG_BIT];
	assign ext_irq1_req = st_r.control[tdc_pkg::EXT_IRQ1_FLAG_BIT];
	assign tmr1_ovf_pulse = st_r.ovf_pulse;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);

	a_sixteen_wrap: assert property (
		(tmr0_mode == tdc_pkg::MODE_16BIT) && cnt_en0 && (&st_r.tmr0_low_byte)
		&& (&st_r.tmr0_high_byte) && !sfr_wr_en
		|=> tmr0_irq && (st_r.tmr0_low_byte == 8'h00) && (st_r.tmr0_high_byte == 8'h00))
		else $error("16-bit rollover did not clear count and set flag");
	a_thirteen_carry: assert property (
		(tmr0_mode == tdc_pkg::MODE_13BIT) && cnt_en0 && (&st_r.tmr0_low_byte[4:0])
		&& !(&st_r.tmr0_high_byte) && !sfr_wr_en
		|=> (st_r.tmr0_high_byte == 8'($past(st_r.tmr0_high_byte) + 8'h01))
		&& (st_r.tmr0_low_byte[4:0] == 5'h00))
		else $error("13-bit carry into high byte wrong");
	a_reload_copy: assert property (
		(tmr0_mode == tdc_pkg::MODE_AUTO_RELOAD) && cnt_en0 && (&st_r.tmr0_low_byte)
		&& !sfr_wr_en
		|=> (st_r.tmr0_low_byte == $past(st_r.tmr0_high_byte)) && $stable(st_r.tmr0_high_byte))
		else $error("auto-reload did not copy high byte");
	a_run_stops: assert property (
		!st_r.control[tdc_pkg::TMR0_RUN_CONTROL_BIT] && !split0 && !sfr_wr_en
		|=> $stable(st_r.tmr0_low_byte) && $stable(st_r.tmr0_high_byte))
		else $error("timer 0 counted while stopped");
	a_gate_blocks: assert property (
		st_r.mode[tdc_pkg::TMR1_PIN_GATING_BIT] && !ext_irq_pin_one && !sfr_wr_en
		|=> $stable(st_r.tmr1_low_byte) && $stable(st_r.tmr1_high_byte))
		else $error("timer 1 counted with gate pin low");
	a_split_halt: assert property (
		(tmr1_mode == tdc_pkg::MODE_SPLIT) && !sfr_wr_en
		|=> $stable(st_r.tmr1_low_byte) && !tmr1_ovf_pulse)
		else $error("timer 1 moved in split mode");
	a_split_high: assert property (
		hi0_en && (&st_r.tmr0_high_byte) && !wr_hi0 && !wr_ctrl |=> tmr1_irq)
		else $error("split high byte overflow missed timer 1 flag");
	a_level_set: assert property (
		!st_r.control[tdc_pkg::EXT_IRQ0_TYPE_BIT] && !ext_irq_pin_zero |=> ext_irq0_req)
		else $error("low level did not set interrupt 0 flag");
	a_edge_ack: assert property (
		st_r.control[tdc_pkg::EXT_IRQ1_TYPE_BIT] && ext_irq1_ack && !fall_irq1 && !wr_ctrl
		|=> !ext_irq1_req)
		else $error("edge flag not cleared on service");
	a_ovf_ack: assert property (
		tmr0_irq_ack && !ovf0 && !wr_ctrl |=> !tmr0_irq)
		else $error("overflow flag not cleared on service");
	a_serial_tick: assert property (
		ovf1 |=> tmr1_ovf_pulse ##1 !tmr1_ovf_pulse)
		else $error("serial rate pulse missing");

endmodule // tdc_timer_pair

`default_nettype wire

/* tdc_core_model.sv */
/*
 * Behavioural model of the processor core as seen by the timer block: it
 * vectors to a pending interrupt and returns a one-clock acknowledge.
 * Assumes the bench enables servicing per source and picks the latency.
 */
`timescale 1ns/1ps
`default_nettype none

module tdc_core_model (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic nrst,
	// Servicing enable and slow-answer choice per source.
	input wire logic [3:0] svc_en,
	input wire logic [3:0] svc_slow,
	// Pending requests in, acknowledges out.
	input wire logic [3:0] irq,
	output logic [3:0] ack
);
	// Latency counter of each source.
	logic [3:0] wait_cnt [4];

	// Acknowledges move on the falling edge, clear of the sampling edge.
	always @(negedge core_clk or negedge nrst) begin
		for (int i = 0; i < 4; i++) begin
			if (!nrst) begin
				ack[i] <= 1'b0;
				wait_cnt[i] <= 4'h0;
			end else if (ack[i]) begin
				// A vector is a single pulse; a level flag may be acked again.
				ack[i] <= 1'b0;
			end else if (svc_en[i] && irq[i]) begin
				if (wait_cnt[i] >= (svc_slow[i] ? 4'h9 : 4'h0)) begin
					ack[i] <= 1'b1;
					wait_cnt[i] <= 4'h0;
				end else begin
					wait_cnt[i] <= wait_cnt[i] + 4'h1;
				end
			end
		end
	end
endmodule // tdc_core_model

`default_nettype wire

/* dual_timer_counter_ext_int_tb.sv */
/*
 * Self-checking bench of the dual timer/counter: drives the register port
 * and pins at the falling edge, with a core model answering interrupts.
 * Assumes the package, design and core model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module dual_timer_counter_ext_int_tb;
	// Register addresses used here.
	localparam logic [7:0] CTL = tdc_pkg::TIMER_RUN_AND_EXT_INT_CONTROL_ADDR;
	localparam logic [7:0] MOD = tdc_pkg::TIMER_MODE_SELECT_ADDR;
	localparam logic [7:0] LO = tdc_pkg::TMR0_LOW_BYTE_ADDR;
	localparam logic [7:0] HI = tdc_pkg::TMR0_HIGH_BYTE_ADDR;
	// Clock, reset and register port.
	logic core_clk, nrst, sfr_wr_en, sfr_rd_en;
	logic [7:0] sfr_addr, sfr_wr_data;
	wire logic [7:0] sfr_rd_data;
	// Pins, requests, acknowledges and servicing controls.
	logic [1:0] ext_pin, cnt_pin;
	logic [3:0] svc_en, svc_slow;
	wire logic [3:0] irq, ack;
	wire logic ovf_pulse;
	wire logic [4:0] evts = {ovf_pulse, irq};
	// Bench state.
	int failures, cmp_count, k;
	logic [31:0] seed;
	logic [7:0] rd, v;

	tdc_timer_pair dut (
		.core_clk(core_clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
		.sfr_wr_data(sfr_wr_data), .sfr_rd_en(sfr_rd_en), .sfr_rd_data(sfr_rd_data),
		.ext_irq_pin_zero(ext_pin[0]), .ext_irq_pin_one(ext_pin[1]),
		.count_pin_zero(cnt_pin[0]), .count_pin_one(cnt_pin[1]),
		.tmr0_irq_ack(ack[0]), .tmr1_irq_ack(ack[1]), .ext_irq0_ack(ack[2]),
		.ext_irq1_ack(ack[3]), .tmr0_irq(irq[0]), .tmr1_irq(irq[1]),
		.ext_irq0_req(irq[2]), .ext_irq1_req(irq[3]), .tmr1_ovf_pulse(ovf_pulse));

	tdc_core_model core (.core_clk(core_clk), .nrst(nrst), .svc_en(svc_en),
		.svc_slow(svc_slow), .irq(irq), .ack(ack));

	// Free-running 20 MHz clock.
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// Random source: fixed-seed shift register, so runs repeat exactly.
	function automatic logic [7:0] rnd();
		seed = {1'b0, seed[31:1]} ^ (seed[0] ? 32'h80200003 : 32'h00000000);
		return seed[7:0];
	endfunction

	// Low byte expected after a rollover from a low byte of all ones.
	function automatic logic [7:0] exp_low(input int m, input logic [7:0] lo,
		input logic [7:0] hi);
		if (m == 0)
			return {lo[7:5], 5'h00};
		return (m == 2) ? hi : 8'h00;
	endfunction

	// One register write: strobe for one clock, then an idle clock follows.
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		sfr_addr = a;
		sfr_wr_data = d;
		sfr_wr_en = 1'b1;
		@(negedge core_clk);
		sfr_wr_en = 1'b0;
	endtask

	// One register read: data is registered, so it is taken a clock later.
	task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		sfr_addr = a;
		sfr_rd_en = 1'b1;
		@(negedge core_clk);
		sfr_rd_en = 1'b0;
		d = sfr_rd_data;
	endtask

	task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk_bit(input string what, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %b seen %b", what, e, g);
		end
	endtask

	task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
		sfr_rd(a, rd);
		chk_byte($sformatf("register %h", a), e, rd);
	endtask

	// Bounded wait on a request or pulse; running out ends the run.
	task automatic wait_for(input int i, input logic val, input int lim);
		int n;
		n = 0;
		while (evts[i] !== val && n < lim) begin
			@(negedge core_clk);
			n++;
		end
		if (evts[i] !== val) begin
			failures++;
			$display("CHECK FAILED event %0d expected %b seen %b", i, val, evts[i]);
			print_verdict();
		end
	endtask

	// Let the core vector to source i and wait for its flag to drop.
	task automatic ack_flag(input int i);
		v = rnd();
		svc_slow[i] <= v[0];
		svc_en[i] <= 1'b1;
		wait_for(i, 1'b0, 20);
		svc_en[i] <= 1'b0;
	endtask

	task automatic load(input int t, input logic [7:0] lo, input logic [7:0] hi);
		sfr_wr(LO + 8'(t), lo);
		sfr_wr(HI + 8'(t), hi);
	endtask

	task automatic done(input string name);
		$display("test %s done", name);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Main sequence.
	initial begin
		seed = 32'h527CB221;
		failures = 0;
		cmp_count = 0;
		nrst = 1'b0;
		{sfr_wr_en, sfr_rd_en, sfr_addr, sfr_wr_data} = 18'h00000;
		ext_pin = 2'h3;
		cnt_pin = 2'h3;
		svc_en = 4'h0;
		svc_slow = 4'h0;
		repeat (3) @(negedge core_clk);
		nrst = 1'b1;
		// Everything reads zero; the unmapped place ignores writes too.
		sfr_wr(8'h87, 8'hFF);
		for (int a = 8'h87; a <= 8'h8D; a++)
			chk_reg(8'(a), 8'h00);
		chk_byte("requests", 8'h00, {3'h0, evts});
		done("reset");
		for (k = 0; k < 4; k++) begin
			v = rnd();
			sfr_wr(MOD, v);
			chk_reg(MOD, v);
		end
		done("mode register");
		// Rollover in the 13-bit, 16-bit and auto-reload modes of both timers.
		for (int t = 0; t < 2; t++) begin
			for (int m = 0; m < 3; m++) begin
				v = (m == 2) ? rnd() : 8'hFF;
				sfr_wr(MOD, 8'(m << (4 * t)));
				load(t, 8'hFF, v);
				sfr_wr(CTL, t ? 8'h40 : 8'h10);
				wait_for(t, 1'b1, 30);
				if (t == 1)
					wait_for(4, 1'b1, 3);
				sfr_wr(CTL, t ? 8'h80 : 8'h20);
				chk_reg(LO + 8'(t), exp_low(m, 8'hFF, v));
				chk_reg(HI + 8'(t), (m == 2) ? v : 8'h00);
				ack_flag(t);
			end
		end
		done("rollover");
		// Carry out of the five low bits into the high byte, one tick only.
		v = rnd() & 8'h7F;
		sfr_wr(MOD, 8'h00);
		load(0, 8'h3F, v);
		sfr_wr(CTL, 8'h10);
		repeat (10) @(negedge core_clk);
		sfr_wr(CTL, 8'h00);
		chk_reg(HI, 8'(v + 8'h01));
		chk_reg(LO, 8'h20);
		done("carry");
		// Rate: about 1200 clocks must give 100 machine cycles.
		sfr_wr(MOD, 8'h01);
		load(0, 8'h00, 8'h00);
		sfr_wr(CTL, 8'h10);
		repeat (1198) @(negedge core_clk);
		sfr_wr(CTL, 8'h00);
		sfr_rd(LO, rd);
		chk_bit("rate", 1'b1, rd >= 8'h63 && rd <= 8'h65);
		done("rate");
		// Gating on both timers: a low pin holds the timer, a high pin lets it run.
		for (int t = 0; t < 2; t++) begin
			sfr_wr(MOD, t ? 8'h90 : 8'h09);
			load(t, 8'h00, 8'h00);
			ext_pin[t] = 1'b0;
			sfr_wr(CTL, t ? 8'h40 : 8'h10);
			repeat (60) @(negedge core_clk);
			chk_reg(LO + 8'(t), 8'h00);
			ext_pin[t] = 1'b1;
			repeat (60) @(negedge core_clk);
			sfr_wr(CTL, 8'h00);
			sfr_rd(LO + 8'(t), v);
			chk_bit("gated count", 1'b1, v >= 8'h04 && v <= 8'h06);
			repeat (60) @(negedge core_clk);
			chk_reg(LO + 8'(t), v);
		end
		done("gating");
		// Counter function: one count per slow falling event on the pin.
		for (int t = 0; t < 2; t++) begin
			sfr_wr(MOD, t ? 8'h50 : 8'h05);
			load(t, 8'h00, 8'h00);
			sfr_wr(CTL, t ? 8'h40 : 8'h10);
			k = int'(rnd() % 8'h08) + 1;
			repeat (k) begin
				cnt_pin[t] = 1'b0;
				repeat (24) @(negedge core_clk);
				cnt_pin[t] = 1'b1;
				repeat (24) @(negedge core_clk);
			end
			sfr_wr(CTL, 8'h00);
			chk_reg(LO + 8'(t), 8'(k));
		end
		done("counter");
		// Split mode: timer 0 is two counters, timer 1 holds.
		sfr_wr(MOD, 8'h33);
		load(0, 8'hFF, 8'hFF);
		load(1, 8'h12, 8'h34);
		sfr_wr(CTL, 8'h50);
		wait_for(0, 1'b1, 30);
		chk_bit("split high flag", 1'b1, irq[1]);
		sfr_wr(CTL, 8'hA0);
		chk_reg(LO, 8'h00);
		chk_reg(HI, 8'h00);
		chk_reg(LO + 8'h01, 8'h12);
		chk_reg(HI + 8'h01, 8'h34);
		ack_flag(0);
		ack_flag(1);
		done("split");
		// External interrupts in both trigger types.
		for (int i = 0; i < 2; i++) begin
			sfr_wr(CTL, i ? 8'h04 : 8'h01);
			repeat (30) @(negedge core_clk);
			ext_pin[i] = 1'b0;
			wait_for(2 + i, 1'b1, 40);
			ack_flag(2 + i);
			repeat (30) @(negedge core_clk);
			chk_bit("edge flag", 1'b0, irq[2 + i]);
			ext_pin[i] = 1'b1;
			sfr_wr(CTL, 8'h00);
			ext_pin[i] = 1'b0;
			wait_for(2 + i, 1'b1, 3);
			svc_en[2 + i] <= 1'b1;
			repeat (30) @(negedge core_clk);
			chk_bit("level flag", 1'b1, irq[2 + i]);
			svc_en[2 + i] <= 1'b0;
			ext_pin[i] = 1'b1;
			sfr_wr(CTL, 8'h00);
			@(negedge core_clk);
			chk_bit("level clear", 1'b0, irq[2 + i]);
		end
		done("external");
		print_verdict();
	end
endmodule // dual_timer_counter_ext_int_tb

`default_nettype wire
